// file: lvdc_ctrl.sv
// low voltage detector control logic with axi4-lite register slave
`timescale 1ns/1ps
module lvdc_ctrl
    import lvdc_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic        OTHER_RESET,
    input  wire logic        CMP_BELOW,
    output logic             CMP_ENABLE,
    output logic             LEVEL_LOW,
    output logic             DET_RESET,
    output logic             IRQ_REQUEST,
    output logic             IRQ_OUT,
    output logic [2:0]       P12_OE,
    input  wire logic [15:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [15:0] S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);
    lvdc_state_t s_r;
    lvdc_state_t s_nxt;
    logic        below;
    logic        wr_go;
    logic        rd_go;
    logic [7:0]  wb;

    //--------------------------------------------------------------------------
    // register decode
    //--------------------------------------------------------------------------
    // address is mapped when it names one of the five byte registers
    function automatic logic mapped(input logic [15:0] a);
        mapped = (a == CTRL_ADDR) || (a == LEVEL_ADDR) || (a == P12DIR_ADDR)
              || (a == RSRC_ADDR) || (a == IRQ_ADDR);
    endfunction

    // comparator output qualified by enable
    assign below = s_r.cmp_sync[1] & s_r.en;
    assign wr_go = s_r.awv & s_r.wv & ~s_r.bvalid;
    assign rd_go = S_AXI_ARVALID & ~s_r.rvalid;
    assign wb    = s_r.wdata[7:0];

    //--------------------------------------------------------------------------
    // next state
    //--------------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // synchroniser, second stage alone is read
        s_nxt.cmp_sync = {s_r.cmp_sync[0], CMP_BELOW};
        // reset mode asserts reset while below, releases when at or above
        s_nxt.det_rst = s_r.en & s_r.mode & below;
        // interrupt mode event sets pending; set wins over software clear
        if (wr_go && s_r.awaddr == IRQ_ADDR && s_r.wstrb[0]) begin
            s_nxt.pend = wb[IRQ_PEND_BIT];
            s_nxt.mask = wb[IRQ_MASK_BIT];
        end
        if (below && !s_r.mode) begin
            s_nxt.pend = 1'b1;
        end
        // axi write channels
        if (S_AXI_AWVALID && !s_r.awv) begin
            s_nxt.awv    = 1'b1;
            s_nxt.awaddr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !s_r.wv) begin
            s_nxt.wv    = 1'b1;
            s_nxt.wdata = S_AXI_WDATA;
            s_nxt.wstrb = S_AXI_WSTRB;
        end
        if (wr_go) begin
            s_nxt.awv    = 1'b0;
            s_nxt.wv     = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = mapped(s_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
            // only byte lane 0 holds register bits; other lanes are ignored
            if (s_r.wstrb[0]) begin
                unique case (s_r.awaddr)
                    CTRL_ADDR: begin
                        s_nxt.en   = wb[CTRL_EN_BIT];
                        s_nxt.mode = wb[CTRL_MODE_BIT];
                    end
                    LEVEL_ADDR:  s_nxt.level  = wb[0]; // bits 7:1 read zero
                    P12DIR_ADDR: s_nxt.p12dir = wb[2:0];
                    RSRC_ADDR:   ;
                    IRQ_ADDR:    ;
                    default:     ;
                endcase
            end
        end
        if (s_r.bvalid && S_AXI_BREADY) begin
            s_nxt.bvalid = 1'b0;
        end
        // axi read
        if (rd_go) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
            s_nxt.rdata  = 32'h0000_0000;
            unique case (S_AXI_ARADDR)
                CTRL_ADDR:   s_nxt.rdata[7:0] = {s_r.en, 5'h00, s_r.mode, below};
                LEVEL_ADDR:  s_nxt.rdata[7:0] = {7'h00, s_r.level};
                P12DIR_ADDR: s_nxt.rdata[7:0] = P12DIR_FIX | {5'h00, s_r.p12dir};
                RSRC_ADDR:   s_nxt.rdata[7:0] = {7'h00, s_r.rsrc};
                IRQ_ADDR:    s_nxt.rdata[7:0] = {6'h00, s_r.mask, s_r.pend};
                default:     ;
            endcase
        end
        if (s_r.rvalid && S_AXI_RREADY) begin
            s_nxt.rvalid = 1'b0;
        end
    end

    //--------------------------------------------------------------------------
    // state register and reset behaviour
    //--------------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET || OTHER_RESET || s_r.det_rst) begin
            s_r          <= s_nxt;
            s_r.level    <= LEVEL_RST[0];
            s_r.p12dir   <= P12DIR_RST[2:0];
            s_r.mask     <= 1'b1;
            s_r.pend     <= 1'b0;
            s_r.awv      <= 1'b0;
            s_r.wv       <= 1'b0;
            s_r.bvalid   <= 1'b0;
            s_r.rvalid   <= 1'b0;
            // a detector reset keeps its request from s_nxt, so it stands for as
            // long as the supply stays low rather than chopping itself into pulses
            if (RESET || OTHER_RESET) begin
                s_r.det_rst  <= 1'b0;
                s_r.en       <= CTRL_RST[CTRL_EN_BIT];
                s_r.mode     <= CTRL_RST[CTRL_MODE_BIT];
                s_r.rsrc     <= 1'b0;
                s_r.cmp_sync <= 2'b00;
                s_r.awaddr   <= 16'h0000;
                s_r.wdata    <= 32'h0000_0000;
                s_r.wstrb    <= 4'h0;
                s_r.rdata    <= 32'h0000_0000;
                s_r.bresp    <= RESP_OKAY;
                s_r.rresp    <= RESP_OKAY;
            end else begin
                s_r.en   <= s_r.en;
                s_r.mode <= s_r.mode;
                s_r.rsrc <= 1'b1;
            end
        end else begin
            s_r <= s_nxt;
        end
    end

    //--------------------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------------------
    assign CMP_ENABLE    = s_r.en;
    assign LEVEL_LOW     = s_r.level;
    assign DET_RESET     = s_r.det_rst;
    assign IRQ_REQUEST   = s_r.pend;
    assign IRQ_OUT       = s_r.pend & ~s_r.mask;
    assign P12_OE        = ~s_r.p12dir;
    assign S_AXI_AWREADY = ~s_r.awv;
    assign S_AXI_WREADY  = ~s_r.wv;
    assign S_AXI_BVALID  = s_r.bvalid;
    assign S_AXI_BRESP   = s_r.bresp;
    assign S_AXI_ARREADY = ~s_r.rvalid;
    assign S_AXI_RVALID  = s_r.rvalid;
    assign S_AXI_RDATA   = s_r.rdata;
    assign S_AXI_RRESP   = s_r.rresp;

    //--------------------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET || OTHER_RESET);

    // reset mode path
    rst_when_below_a: assert property (
        s_r.en && s_r.mode && below && !DET_RESET |=> DET_RESET)
        else $error("no detector reset while below");
    no_rst_above_a: assert property (
        !below |=> !DET_RESET)
        else $error("detector reset while above");
    rst_keeps_en_a: assert property (
        DET_RESET |=> $stable(s_r.en) && $stable(s_r.mode))
        else $error("detector reset changed enable");
    rst_src_set_a: assert property (
        DET_RESET |=> s_r.rsrc)
        else $error("reset source not set");
    mask_after_rst_a: assert property (
        DET_RESET |=> s_r.mask && !s_r.level)
        else $error("mask or level wrong after reset");

    // interrupt request path
    irq_below_a: assert property (
        below && !s_r.mode |=> IRQ_REQUEST)
        else $error("interrupt not raised");
    irq_hold_a: assert property (
        IRQ_REQUEST && !DET_RESET && !(wr_go && s_r.awaddr == IRQ_ADDR)
        |=> IRQ_REQUEST) else $error("pending request lost");
    irq_quiet_a: assert property (
        (!s_r.en || s_r.mode) && !IRQ_REQUEST && !(wr_go && s_r.awaddr == IRQ_ADDR)
        |=> !IRQ_REQUEST) else $error("request outside interrupt mode");

    // register and pin path
    flag_off_a: assert property (
        rd_go && S_AXI_ARADDR == CTRL_ADDR && !s_r.en
        |=> !S_AXI_RDATA[CTRL_FLAG_BIT]) else $error("flag high while disabled");
    oe_dir_a: assert property (
        wr_go && s_r.awaddr == P12DIR_ADDR && s_r.wstrb[0] && !DET_RESET
        |=> P12_OE == ~$past(wb[2:0])) else $error("pin enable mismatch");
    dir_read_a: assert property (
        rd_go && S_AXI_ARADDR == P12DIR_ADDR
        |=> S_AXI_RDATA[7:3] == 5'h1f) else $error("direction high bits");

    // main scenarios reached
    cov_det_rst_c:  cover property (DET_RESET ##1 !DET_RESET);
    cov_irq_c:      cover property (IRQ_OUT);
    cov_write_c:    cover property (S_AXI_BVALID && S_AXI_BREADY);
    cov_read_c:     cover property (S_AXI_RVALID && S_AXI_RREADY);
    cov_slverr_c:   cover property (S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR);
endmodule

// file: lvdc_pkg.sv
// package of constants and types for the low voltage detector control block
//------------------------------------------------------------------------------
// Operation
// - level select cleared by any reset
// - level bit chooses high or low threshold
// - port12 direction resets ones, bits 7:3 one
// - direction bit zero drives pin, one inputs
// - reset mode: reset while supply below threshold
// - interrupt mode: request on supply below threshold
// - mode set above threshold gives no reset
// - any reset sets detector interrupt mask
// - control register resets zero, bits 7,1,0
// - detector reset keeps enable and mode bits
// - flag drives request only enabled, interrupt mode
// - detector reset sets reset source bit 0
//------------------------------------------------------------------------------
package lvdc_pkg;
    // register byte addresses
    localparam logic [15:0] CTRL_ADDR   = 16'hffbe;
    localparam logic [15:0] LEVEL_ADDR  = 16'hffbf;
    localparam logic [15:0] P12DIR_ADDR = 16'hff2c;
    localparam logic [15:0] RSRC_ADDR   = 16'hfea8;
    localparam logic [15:0] IRQ_ADDR    = 16'hfea0;
    // field positions
    localparam int CTRL_EN_BIT   = 7;
    localparam int CTRL_MODE_BIT = 1;
    localparam int CTRL_FLAG_BIT = 0;
    localparam int IRQ_PEND_BIT  = 0;
    localparam int IRQ_MASK_BIT  = 1;
    localparam int RSRC_DET_BIT  = 0;
    // reset values, fixed read bits and response codes
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] LEVEL_RST  = 8'h00;
    localparam logic [7:0] P12DIR_RST = 8'hff;
    localparam logic [7:0] P12DIR_FIX = 8'hf8;
    localparam logic [1:0] RESP_OKAY  = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic       en;
        logic       mode;
        logic       level;
        logic [2:0] p12dir;
        logic       pend;
        logic       mask;
        logic       rsrc;
        logic [1:0] cmp_sync;
        logic       det_rst;
        logic       awv;
        logic       wv;
        logic [15:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } lvdc_state_t;
endpackage

// file: test_lvdc_ctrl.sv
// self-checking bench for the low voltage detector control block
`timescale 1ns/1ps
module test_lvdc_ctrl
    import lvdc_pkg::*;
;
    //--------------------------------------------------------------------------
    // stimulus and observed signals
    //--------------------------------------------------------------------------
    logic        clk     = 1'b0;
    logic        rst     = 1'b1;
    logic        oth_rst = 1'b0;
    logic        below   = 1'b0;
    logic        cmp_en, lvl_low, det_rst, irq_req, irq_out;
    logic [2:0]  p12_oe;
    logic [15:0] awaddr  = 16'h0000;
    logic [15:0] araddr  = 16'h0000;
    logic [31:0] wdata   = 32'h0;
    logic [3:0]  wstrb   = 4'h0;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        arvalid = 1'b0;
    logic        bready  = 1'b1; // answers are always accepted
    logic        rready  = 1'b1;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rs;
    logic [31:0] rdata, rv;
    int          bad_count   = 0;
    int          checks_done = 0;
    int          cycles      = 0;
    localparam int SETTLE_CYCLES = 1000; // comparator settling, 10 us at 100 MHz

    always #5 clk = ~clk;

    lvdc_ctrl u_lvdc_ctrl (
        .CLK(clk), .RESET(rst), .OTHER_RESET(oth_rst), .CMP_BELOW(below),
        .CMP_ENABLE(cmp_en), .LEVEL_LOW(lvl_low), .DET_RESET(det_rst),
        .IRQ_REQUEST(irq_req), .IRQ_OUT(irq_out), .P12_OE(p12_oe),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
    );

    //--------------------------------------------------------------------------
    // compare, verdict and bus tasks
    //--------------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // write one byte into lane 0, holding each channel until it is taken
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
    endtask

    task automatic rc(input string what, input logic [15:0] a, input logic [31:0] exp);
        rd(a, rv, rs);
        check(what, rv, exp);
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            report_and_stop();
        end
    end

    //--------------------------------------------------------------------------
    // main sequence
    //--------------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rc("ctrl rst", CTRL_ADDR, 32'h0);
        rc("level rst", LEVEL_ADDR, 32'h0);
        rc("p12 rst", P12DIR_ADDR, 32'hff);
        rc("mask rst", IRQ_ADDR, 32'h2);
        check("oe rst", {29'h0, p12_oe}, 32'h0);
        wr(P12DIR_ADDR, 8'h00);
        check("wr okay", {30'h0, bresp}, {30'h0, RESP_OKAY});
        rc("p12 fixed", P12DIR_ADDR, 32'hf8);
        check("oe out", {29'h0, p12_oe}, 32'h7);
        wr(P12DIR_ADDR, 8'h01);
        check("oe detpin", {29'h0, p12_oe}, 32'h6);
        wr(LEVEL_ADDR, 8'h01);
        wr(LEVEL_ADDR, 8'h00, 4'h0); // lane 0 not strobed, ignored
        rc("level", LEVEL_ADDR, 32'h1);
        check("lvl low", {31'h0, lvl_low}, 32'h1);
        // interrupt mode: enable masked, settle, confirm, then request and unmask
        wr(CTRL_ADDR, 8'h80);
        repeat (SETTLE_CYCLES) @(posedge clk);
        rc("flag low", CTRL_ADDR, 32'h80);
        check("en on", {31'h0, cmp_en}, 32'h1);
        below <= 1'b1;
        repeat (5) @(posedge clk);
        rc("flag", CTRL_ADDR, 32'h81);
        check("irq masked", {30'h0, irq_req, irq_out}, 32'h2);
        wr(IRQ_ADDR, 8'h00);
        check("irq out", {30'h0, irq_req, irq_out}, 32'h3);
        below <= 1'b0;
        repeat (5) @(posedge clk);
        wr(IRQ_ADDR, 8'h00);
        check("irq clr", {30'h0, irq_req, irq_out}, 32'h0);
        // stopped detector ignores the comparator
        wr(CTRL_ADDR, 8'h00);
        below <= 1'b1;
        repeat (5) @(posedge clk);
        check("off", {29'h0, cmp_en, irq_req, irq_out}, 32'h0);
        rc("flag off", CTRL_ADDR, 32'h0);
        // reset mode: no reset above level, reset while below
        below <= 1'b0;
        wr(IRQ_ADDR, 8'h02);
        wr(CTRL_ADDR, 8'h80);
        repeat (SETTLE_CYCLES) @(posedge clk);
        rc("flag ok", CTRL_ADDR, 32'h80);
        wr(CTRL_ADDR, 8'h82);
        repeat (5) @(posedge clk);
        check("no det rst", {31'h0, det_rst}, 32'h0);
        below <= 1'b1;
        repeat (5) @(posedge clk);
        check("det rst", {31'h0, det_rst}, 32'h1);
        below <= 1'b0;
        repeat (6) @(posedge clk);
        check("det rel", {31'h0, det_rst}, 32'h0);
        rc("ctrl kept", CTRL_ADDR, 32'h82);
        rc("rsrc set", RSRC_ADDR, 32'h1);
        rc("level clr", LEVEL_ADDR, 32'h0);
        rc("mask set", IRQ_ADDR, 32'h2);
        check("lvl rst", {31'h0, lvl_low}, 32'h0);
        // stop reset mode bit by bit: mode first, then enable
        wr(CTRL_ADDR, 8'h80);
        rc("mode off", CTRL_ADDR, 32'h80);
        wr(CTRL_ADDR, 8'h00);
        rc("stopped", CTRL_ADDR, 32'h0);
        // another reset source clears enable and the reset source flag
        wr(CTRL_ADDR, 8'h80);
        oth_rst <= 1'b1;
        @(posedge clk);
        oth_rst <= 1'b0;
        rc("ctrl oth", CTRL_ADDR, 32'h0);
        rc("rsrc clr", RSRC_ADDR, 32'h0);
        rd(16'h0000, rv, rs);
        check("unmapped", {rs, rv[29:0]}, {RESP_SLVERR, 30'h0});
        wr(16'h0000, 8'h00);
        check("wr unmapped", {30'h0, bresp}, {30'h0, RESP_SLVERR});
        report_and_stop();
    end
endmodule
